// [hw/bulk_only_pkg.sv]
// Constants, types and register map of the bulk-only channel support block
package bulk_only_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [9:0] IDX_SEQ_CONTROL = 10'h19a;
  localparam logic [9:0] IDX_STATUS_WRAPPER_RX_SIZE = 10'h19b;
  localparam logic [9:0] IDX_BULK_OUT_ENDPOINT_CTL = 10'h19c;
  localparam logic [9:0] IDX_BULK_IN_ENDPOINT_CTL = 10'h19d;
  localparam logic [9:0] IDX_TRANSFER_RESULT_CODE = 10'h19e;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h1f0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h1f1;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LAUNCH_BIT = 0;
  localparam int PHASE_LSB = 4;
  localparam int TOGGLE_BIT = 4;
  localparam int RESULT_LSB = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_STOP_BIT = 1;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_NIBBLE = 4'h0;
  localparam logic [2:0] RESET_RESULT = 3'h0;
  localparam logic [1:0] RESET_IRQ = 2'h0;

  // ----------------------------------------------------------------------
  // Completion codes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    RESULT_NO_ERROR = 3'b000,
    RESULT_STALL = 3'b001,
    RESULT_OVERRUN = 3'b010,
    RESULT_UNDERRUN = 3'b011,
    RESULT_RETRY = 3'b100
  } transfer_result_t;

  // ----------------------------------------------------------------------
  // Sequence phases, equal to the readable phase field
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b00,
    PHASE_COMMAND = 2'b01,
    PHASE_DATA = 2'b10,
    PHASE_STATUS = 2'b11
  } auto_sequence_phase_t;

  // ----------------------------------------------------------------------
  // Transaction engine carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic isIn;
    logic [3:0] endpoint;
    logic toggle;
    logic [1:0] phase;
  } transport_req_t;

  typedef struct packed {
    logic done;
    logic [2:0] result;
    logic toggle;
    logic [3:0] byteCount;
    logic handshakeOnly;
    logic wrapperValid;
  } transport_rsp_t;

endpackage : bulk_only_pkg

// [hw/host_bulk_only_endpoint_ctl.sv]
// Bulk-only sequencer and its register file on a classic Wishbone slave
//
// Behaviour
// - Four-bit read-only status wrapper byte count
// - Byte count valid on short status receipt
// - OUT toggle bit seeds command/data-out toggle
// - Normal OUT end writes toggle back
// - OUT tokens use writable OUT endpoint
// - IN toggle bit seeds status/data-in toggle
// - Normal IN end writes toggle back
// - IN tokens use writable IN endpoint
// - Three-bit result code, bits six to four
// - Result codes: none, stall, overrun, underrun, retry
// - Command out, optional data, status in
// - Phase field shows idle, command, data, status
// - Stop flag on error or software abort; after an error stop, code zero means bad wrapper
module host_bulk_only_endpoint_ctl (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dataStageEnable,
  input wire logic dataStageIn,
  output bulk_only_pkg::transport_req_t transportReq,
  input wire bulk_only_pkg::transport_rsp_t transportRsp,
  output logic irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  bulk_only_pkg::auto_sequence_phase_t phase;
  bulk_only_pkg::auto_sequence_phase_t next_phase;
  logic autoSequenceLaunch;
  logic [3:0] statusWrapperByteCount;
  logic outDirToggle;
  logic [3:0] outDirEndpoint;
  logic inDirToggle;
  logic [3:0] inDirEndpoint;
  logic [2:0] transferResult;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;

  logic access;
  logic wrLow;
  logic [9:0] regIndex;
  logic launchWrite;
  logic launchClear;
  logic running;
  logic transportEnd;
  logic transportOk;
  logic endIsIn;
  logic seqDone;
  logic seqStop;
  logic [1:0] irqSet;

  // Register write strobe for one index, low byte lane only
  function automatic logic regWrite(input logic [9:0] idx,
                                    input logic [9:0] want,
                                    input logic wr);
    regWrite = wr && (idx == want);
  endfunction : regWrite

  // Reserved engine codes fold into a retry error, so software
  // never reads a code that has no meaning
  function automatic logic [2:0] foldResult(input logic [2:0] code);
    unique case (code)
      bulk_only_pkg::RESULT_NO_ERROR,
      bulk_only_pkg::RESULT_STALL,
      bulk_only_pkg::RESULT_OVERRUN,
      bulk_only_pkg::RESULT_UNDERRUN,
      bulk_only_pkg::RESULT_RETRY: begin
        foldResult = code;
      end
      default: begin
        foldResult = bulk_only_pkg::RESULT_RETRY;
      end
    endcase
  endfunction : foldResult

  // Direction of the transport run in a given phase
  function automatic logic phaseIsIn(input logic [1:0] ph,
                                     input logic dataIn);
    phaseIsIn = (ph == bulk_only_pkg::PHASE_STATUS) ||
                ((ph == bulk_only_pkg::PHASE_DATA) && dataIn);
  endfunction : phaseIsIn

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrLow = access && wb_we_i && wb_sel_i[0];
  assign regIndex = wb_adr_i[11:2];
  assign launchWrite = regWrite(regIndex, bulk_only_pkg::IDX_SEQ_CONTROL,
                                wrLow);
  assign running = (phase != bulk_only_pkg::PHASE_IDLE) && autoSequenceLaunch;

  // Ack one cycle after the strobe, dropped the cycle after
  // Masking access with ack stops one strobe from being taken twice
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  // ----------------------------------------------------------------------
  // Transport completion
  // ----------------------------------------------------------------------
  assign transportEnd = running && transportReq.valid && transportRsp.done;
  assign endIsIn = phaseIsIn(phase, dataStageIn);
  assign transportOk = transportEnd &&
                       (transportRsp.result == bulk_only_pkg::RESULT_NO_ERROR) &&
                       ((phase != bulk_only_pkg::PHASE_STATUS) ||
                        transportRsp.wrapperValid);
  // Software clearing the launch bit aborts unless status just ended well
  assign launchClear = launchWrite && !wb_dat_i[bulk_only_pkg::LAUNCH_BIT];
  assign seqDone = transportOk && (phase == bulk_only_pkg::PHASE_STATUS);
  assign seqStop = running && !seqDone &&
                   ((transportEnd && !transportOk) || launchClear);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_phase = phase;
    unique case (phase)
      bulk_only_pkg::PHASE_IDLE: begin
        if (launchWrite && wb_dat_i[bulk_only_pkg::LAUNCH_BIT]) begin
          next_phase = bulk_only_pkg::PHASE_COMMAND;
        end
      end
      bulk_only_pkg::PHASE_COMMAND: begin
        if (transportOk) begin
          next_phase = dataStageEnable ? bulk_only_pkg::PHASE_DATA :
                                         bulk_only_pkg::PHASE_STATUS;
        end
      end
      bulk_only_pkg::PHASE_DATA: begin
        if (transportOk) begin
          next_phase = bulk_only_pkg::PHASE_STATUS;
        end
      end
      bulk_only_pkg::PHASE_STATUS: begin
        if (seqDone) begin
          next_phase = bulk_only_pkg::PHASE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= bulk_only_pkg::PHASE_IDLE;
    end else if (seqStop) begin
      phase <= phase;
    end else if (!autoSequenceLaunch && launchWrite &&
                 wb_dat_i[bulk_only_pkg::LAUNCH_BIT]) begin
      phase <= bulk_only_pkg::PHASE_COMMAND;
    end else if (running) begin
      phase <= next_phase;
    end
  end

  // Launch bit clears itself when the sequence ends either way
  // A stop leaves the phase field showing where the run died
  always_ff @(posedge clk) begin
    if (rst) begin
      autoSequenceLaunch <= 1'b0;
    end else if (seqDone || seqStop) begin
      autoSequenceLaunch <= 1'b0;
    end else if (launchWrite) begin
      autoSequenceLaunch <= wb_dat_i[bulk_only_pkg::LAUNCH_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Transport request; dropped for one cycle between transports
  // ----------------------------------------------------------------------
  // The gap lets the fields pick up the new phase and saved toggle
  // before the engine sees the next request
  always_ff @(posedge clk) begin
    if (rst) begin
      transportReq <= '0;
    end else begin
      transportReq.valid <= running && !transportEnd && !launchClear;
      transportReq.phase <= phase;
      transportReq.isIn <= endIsIn;
      transportReq.endpoint <= endIsIn ? inDirEndpoint : outDirEndpoint;
      transportReq.toggle <= endIsIn ? inDirToggle : outDirToggle;
    end
  end

  // ----------------------------------------------------------------------
  // Endpoint control registers
  // ----------------------------------------------------------------------
  // OUT toggle write back
  always_ff @(posedge clk) begin
    if (rst) begin
      outDirToggle <= 1'b0;
      outDirEndpoint <= bulk_only_pkg::RESET_NIBBLE;
    end else begin
      if (regWrite(regIndex, bulk_only_pkg::IDX_BULK_OUT_ENDPOINT_CTL,
                   wrLow)) begin
        outDirToggle <= wb_dat_i[bulk_only_pkg::TOGGLE_BIT];
        outDirEndpoint <= wb_dat_i[3:0];
      end
      // Hardware save wins over a write in the same cycle
      if (transportOk && !endIsIn) begin
        outDirToggle <= transportRsp.toggle;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      inDirToggle <= 1'b0;
      inDirEndpoint <= bulk_only_pkg::RESET_NIBBLE;
    end else begin
      if (regWrite(regIndex, bulk_only_pkg::IDX_BULK_IN_ENDPOINT_CTL,
                   wrLow)) begin
        inDirToggle <= wb_dat_i[bulk_only_pkg::TOGGLE_BIT];
        inDirEndpoint <= wb_dat_i[3:0];
      end
      if (transportOk && endIsIn) begin
        inDirToggle <= transportRsp.toggle;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------------
  // Count from status data packet
  always_ff @(posedge clk) begin
    if (rst) begin
      statusWrapperByteCount <= bulk_only_pkg::RESET_NIBBLE;
    end else if (transportEnd && (phase == bulk_only_pkg::PHASE_STATUS) &&
                 !transportRsp.handshakeOnly) begin
      statusWrapperByteCount <= transportRsp.byteCount;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      transferResult <= bulk_only_pkg::RESET_RESULT;
    end else if (transportEnd) begin
      // Aborts leave the last code; a stale zero can look like a bad wrapper
      transferResult <= foldResult(transportRsp.result);
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  assign irqSet[bulk_only_pkg::IRQ_DONE_BIT] = seqDone;
  assign irqSet[bulk_only_pkg::IRQ_STOP_BIT] = seqStop;

  // Set beats a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus <= bulk_only_pkg::RESET_IRQ;
    end else if (regWrite(regIndex, bulk_only_pkg::IDX_IRQ_STATUS, wrLow)) begin
      irqStatus <= (irqStatus & ~wb_dat_i[1:0]) | irqSet;
    end else begin
      irqStatus <= irqStatus | irqSet;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqMask <= bulk_only_pkg::RESET_IRQ;
    end else if (regWrite(regIndex, bulk_only_pkg::IDX_IRQ_MASK, wrLow)) begin
      irqMask <= wb_dat_i[1:0];
    end
  end

  // Level output; software drops it by clearing the status bit or its mask bit
  assign irq = |(irqStatus & irqMask);

  // ----------------------------------------------------------------------
  // Read data, registered; unmapped reads zero
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (access && !wb_we_i) begin
      wb_dat_o <= 32'h0000_0000;
      unique case (regIndex)
        bulk_only_pkg::IDX_SEQ_CONTROL: begin
          wb_dat_o[bulk_only_pkg::PHASE_LSB +: 2] <= phase;
          wb_dat_o[bulk_only_pkg::LAUNCH_BIT] <= autoSequenceLaunch;
        end
        bulk_only_pkg::IDX_STATUS_WRAPPER_RX_SIZE: begin
          wb_dat_o[3:0] <= statusWrapperByteCount;
        end
        bulk_only_pkg::IDX_BULK_OUT_ENDPOINT_CTL: begin
          wb_dat_o[bulk_only_pkg::TOGGLE_BIT] <= outDirToggle;
          wb_dat_o[3:0] <= outDirEndpoint;
        end
        bulk_only_pkg::IDX_BULK_IN_ENDPOINT_CTL: begin
          wb_dat_o[bulk_only_pkg::TOGGLE_BIT] <= inDirToggle;
          wb_dat_o[3:0] <= inDirEndpoint;
        end
        bulk_only_pkg::IDX_TRANSFER_RESULT_CODE: begin
          wb_dat_o[bulk_only_pkg::RESULT_LSB +: 3] <= transferResult;
        end
        bulk_only_pkg::IDX_IRQ_STATUS: begin
          wb_dat_o[1:0] <= irqStatus;
        end
        bulk_only_pkg::IDX_IRQ_MASK: begin
          wb_dat_o[1:0] <= irqMask;
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule : host_bulk_only_endpoint_ctl

// [test/bulk_only_function_model.sv]
// Far-side mass-storage endpoint answering each transport
module bulk_only_function_model (
  input wire logic clk,
  input wire logic rst,
  input wire bulk_only_pkg::transport_req_t req,
  output bulk_only_pkg::transport_rsp_t rsp,
  input wire logic [3:0] latency,
  input wire logic [1:0] failPhase,
  input wire logic [2:0] failCode,
  input wire logic [3:0] rxCount,
  input wire logic handshake,
  input wire logic badWrapper
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic [5:0] seen [4];
  logic hit;
  bulk_only_pkg::transport_rsp_t p;
  always_ff @(posedge clk) begin
    if (rst || !req.valid || rsp.done) begin
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
    if (req.valid && cnt == 4'h0) begin
      seen[req.phase] <= {req.isIn, req.toggle, req.endpoint};
    end
  end
  assign hit = req.phase == failPhase;
  always_comb begin
    p.done = 1'b1;
    p.result = hit ? failCode : 3'h0;
    p.toggle = ~req.toggle;
    p.byteCount = rxCount;
    p.handshakeOnly = handshake;
    p.wrapperValid = !(hit && badWrapper);
    // Fields mean nothing outside the done cycle
    rsp = (req.valid && cnt == latency) ? p : {1'b0, ~p[9:0]};
  end
endmodule : bulk_only_function_model

// [test/host_bulk_only_endpoint_ctl_properties.sv]
// Port-level assertions for the bulk-only sequencer
module host_bulk_only_endpoint_ctl_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic dataStageEnable,
  input wire logic dataStageIn,
  input wire bulk_only_pkg::transport_req_t transportReq,
  input wire bulk_only_pkg::transport_rsp_t transportRsp
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // Shorthands
  // --------
  logic rd;
  logic ok;
  logic cmd;
  logic [9:0] ix;
  assign ix = wb_adr_i[11:2];
  assign rd = wb_ack_o && !wb_we_i;
  // Clean done ends a command or data transport normally
  assign ok = transportReq.valid && transportRsp.done &&
    transportRsp.result == 3'h0;
  assign cmd = transportReq.phase == bulk_only_pkg::PHASE_COMMAND;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_size_nibble: assert property (
    rd && ix == bulk_only_pkg::IDX_STATUS_WRAPPER_RX_SIZE |->
    wb_dat_o[31:4] == 28'h000_0000) else $error("Count too wide");
  chk_result_field: assert property (
    rd && ix == bulk_only_pkg::IDX_TRANSFER_RESULT_CODE |->
    wb_dat_o[31:7] == 25'h000_0000 && wb_dat_o[3:0] == 4'h0)
    else $error("Result outside bits 6 to 4");
  chk_cmd_out: assert property (
    $rose(transportReq.valid) && cmd |-> !transportReq.isIn)
    else $error("Command transport not OUT");
  chk_req_release: assert property (
    transportReq.valid && transportRsp.done |=> !transportReq.valid)
    else $error("Request held after done");
  chk_data_next: assert property (
    ok && cmd && dataStageEnable |=> ##1 transportReq.valid &&
    transportReq.phase == bulk_only_pkg::PHASE_DATA &&
    transportReq.isIn == dataStageIn) else $error("No data transport");
  chk_skip_data: assert property (
    ok && cmd && !dataStageEnable |=> ##1 transportReq.valid &&
    transportReq.phase == bulk_only_pkg::PHASE_STATUS &&
    transportReq.isIn) else $error("No status transport");
  chk_out_toggle: assert property (
    ok && cmd && dataStageEnable && !dataStageIn |=> ##1
    transportReq.toggle == $past(transportRsp.toggle, 2))
    else $error("OUT toggle not kept");
  chk_in_toggle: assert property (
    ok && transportReq.isIn &&
    transportReq.phase == bulk_only_pkg::PHASE_DATA |=> ##1
    transportReq.toggle == $past(transportRsp.toggle, 2))
    else $error("IN toggle not kept");
  chk_error_halt: assert property (
    transportReq.valid && transportRsp.done &&
    transportRsp.result != 3'h0 |=> !transportReq.valid [*2])
    else $error("Sequence went on after error");
endmodule : host_bulk_only_endpoint_ctl_properties

bind host_bulk_only_endpoint_ctl host_bulk_only_endpoint_ctl_properties chk_u (
  .clk(clk), .rst(rst), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .dataStageEnable(dataStageEnable), .dataStageIn(dataStageIn),
  .transportReq(transportReq), .transportRsp(transportRsp)
);

// [test/host_bulk_only_endpoint_ctl_tb.sv]
// Register-level test of the bulk-only sequencer
module host_bulk_only_endpoint_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cyc, stb, we, dEn, dIn, irq, ack, hs, bad;
  logic [3:0] sel, lat, rxc;
  logic [1:0] fph;
  logic [2:0] fcode;
  logic [11:0] adr;
  logic [31:0] wdat, dato, rdat, rxExp;
  bulk_only_pkg::transport_req_t req;
  bulk_only_pkg::transport_rsp_t rsp;
  int errors, checks_done;

  host_bulk_only_endpoint_ctl dut_u (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato),
    .wb_ack_o(ack), .dataStageEnable(dEn), .dataStageIn(dIn),
    .transportReq(req), .transportRsp(rsp), .irq(irq)
  );
  bulk_only_function_model fm_u (
    .clk(clk), .rst(rst), .req(req), .rsp(rsp), .latency(lat),
    .failPhase(fph), .failCode(fcode), .rxCount(rxc), .handshake(hs),
    .badWrapper(bad)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // --------
  // Bus and check tasks
  // --------
  task close_out;
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task cmpv(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpv

  task bus(input logic w, input logic [9:0] ix, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'h0};
    wdat <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rdat = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) begin
      errors++;
      close_out();
    end
  endtask : bus

  task rd(input logic [9:0] ix, input logic [31:0] exp);
    bus(1'b0, ix, 8'h00);
    cmpv(rdat, exp);
  endtask : rd

  task launch(input logic [7:0] oc, input logic [7:0] ic,
    input logic de, input logic di);
    int n;
    bus(1'b1, bulk_only_pkg::IDX_BULK_OUT_ENDPOINT_CTL, oc);
    bus(1'b1, bulk_only_pkg::IDX_BULK_IN_ENDPOINT_CTL, ic);
    dEn <= de;
    dIn <= di;
    bus(1'b1, bulk_only_pkg::IDX_SEQ_CONTROL, 8'h01);
    n = 0;
    do begin
      bus(1'b0, bulk_only_pkg::IDX_SEQ_CONTROL, 8'h00);
      n++;
    end while (rdat[0] !== 1'b0 && n < 60);
    if (n >= 60) begin
      errors++;
      close_out();
    end
  endtask : launch

  task run(input logic [7:0] oc, input logic [7:0] ic,
    input logic de, input logic di);
    logic to, ti;
    launch(oc, ic, de, di);
    to = ~oc[4];
    ti = ic[4];
    cmpv({26'h0, fm_u.seen[1]}, {26'h0, 1'b0, oc[4], oc[3:0]});
    if (de) begin
      cmpv({26'h0, fm_u.seen[2]},
        {26'h0, di, di ? ti : to, di ? ic[3:0] : oc[3:0]});
      ti = ti ^ di;
      to = to ^ !di;
    end
    cmpv({26'h0, fm_u.seen[3]}, {26'h0, 1'b1, ti, ic[3:0]});
    rd(bulk_only_pkg::IDX_BULK_OUT_ENDPOINT_CTL, {27'h0, to, oc[3:0]});
    rd(bulk_only_pkg::IDX_BULK_IN_ENDPOINT_CTL, {27'h0, ~ti, ic[3:0]});
    rd(bulk_only_pkg::IDX_STATUS_WRAPPER_RX_SIZE, rxExp);
    rd(bulk_only_pkg::IDX_TRANSFER_RESULT_CODE, 32'h0);
    rd(bulk_only_pkg::IDX_SEQ_CONTROL, 32'h0);
  endtask : run

  // --------
  // Main sequence
  // --------
  initial begin
    {rst, cyc, stb, we, dEn, dIn, hs, bad} = 8'h80;
    sel = 4'h1;
    lat = 4'h3;
    rxc = 4'hd;
    fph = 2'h0;
    fcode = 3'h0;
    {adr, wdat} = 44'h000_0000_0000;
    errors = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(bulk_only_pkg::IDX_SEQ_CONTROL + 10'(i), 32'h0);
    end
    for (int i = 1; i < 5; i++) begin
      bus(1'b1, bulk_only_pkg::IDX_SEQ_CONTROL + 10'(i), 8'hff);
      rd(bulk_only_pkg::IDX_SEQ_CONTROL + 10'(i),
        (i == 2 || i == 3) ? 32'h1f : 32'h0);
    end
    bus(1'b1, 10'h100, 8'hff);
    rd(10'h100, 32'h0);
    bus(1'b1, bulk_only_pkg::IDX_IRQ_MASK, 8'h01);
    rxExp = 32'hd;
    run(8'h1f, 8'h00, 1'b1, 1'b0);
    cmpv({31'h0, irq}, 32'h1);
    bus(1'b1, bulk_only_pkg::IDX_IRQ_STATUS, 8'h01);
    cmpv({31'h0, irq}, 32'h0);
    lat <= 4'h7;
    rxc <= 4'h5;
    rxExp = 32'h5;
    run(8'h00, 8'h1f, 1'b1, 1'b1);
    hs <= 1'b1;
    // Count after a handshake is left alone
    run(8'h05, 8'h13, 1'b0, 1'b0);
    hs <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      fph <= (k == 0) ? 2'h3 : 2'h1;
      fcode <= 3'(k);
      bad <= (k == 0);
      launch(8'h1f, 8'h00, 1'b0, 1'b0);
      rd(bulk_only_pkg::IDX_TRANSFER_RESULT_CODE, {25'h0, 3'(k), 4'h0});
      rd(bulk_only_pkg::IDX_IRQ_STATUS, 32'h2);
      rd(bulk_only_pkg::IDX_SEQ_CONTROL, (k == 0) ? 32'h30 : 32'h10);
      rd(bulk_only_pkg::IDX_BULK_OUT_ENDPOINT_CTL,
        (k == 0) ? 32'hf : 32'h1f);
      cmpv({31'h0, irq}, 32'h0);
    end
    // Software abort in mid command transport
    bus(1'b1, bulk_only_pkg::IDX_IRQ_STATUS, 8'h03);
    bus(1'b1, bulk_only_pkg::IDX_SEQ_CONTROL, 8'h01);
    bus(1'b1, bulk_only_pkg::IDX_SEQ_CONTROL, 8'h00);
    rd(bulk_only_pkg::IDX_IRQ_STATUS, 32'h2);
    rd(bulk_only_pkg::IDX_SEQ_CONTROL, 32'h10);
    close_out();
  end
endmodule : host_bulk_only_endpoint_ctl_tb
